// [src/fdos_cfg.svh]
// constants of the drive output and drive signal status register pair:
// offsets, bit positions, reset values and timing counts.
// assumes a single 10 MHz controller clock; included by bare name.
`ifndef FDOS_CFG_SVH
`define FDOS_CFG_SVH

// register offsets within the eight-byte decoded window
`define FDOS_OFS_STATUS      3'h1
`define FDOS_OFS_OUTCTL      3'h2

// drive signal status bit positions
`define FDOS_ST_DSEL0        5
`define FDOS_ST_WR_TOGGLE    4
`define FDOS_ST_RD_TOGGLE    3
`define FDOS_ST_WRITE_GATE_LINE        2
`define FDOS_ST_MOTOR1       1
`define FDOS_ST_MOTOR0       0

// drive output control field positions
`define FDOS_OC_MOTOR_HI     7
`define FDOS_OC_MOTOR_LO     4
`define FDOS_OC_RSVD         3
`define FDOS_OC_NRESET       2
`define FDOS_OC_DSEL_HI      1
`define FDOS_OC_DSEL_LO      0

// reset values
`define FDOS_OC_RESET_VAL    8'h00
`define FDOS_BYTE_ZERO       8'h00
// idle pin levels held by the synchroniser in reset: {aen, cs_n, addr,
// ior_n, iow_n, data, read pulse}; the active-low lines idle high
`define FDOS_SYNC_IDLE       16'h4601

// least time the controller stays in software reset
`define FDOS_SWRST_MIN_NS    100
`define FDOS_CLK_PERIOD_NS   100
`define FDOS_SWRST_MIN_CYC   ((`FDOS_SWRST_MIN_NS + `FDOS_CLK_PERIOD_NS - 1) / `FDOS_CLK_PERIOD_NS)

`endif

// [src/fdos_pkg.sv]
// types shared by the drive output / status register block.
// assumes the constants header supplies all numeric values.
package fdos_pkg;

    // isa i/o cycle as seen at the pins, all asynchronous to clock_i
    typedef struct packed {
        logic       aen;      // dma address enable, high blocks i/o decode
        logic       cs_n;     // base decode from the board, aliased or not
        logic [2:0] addr;     // low address bits, register offset
        logic       ior_n;    // i/o read strobe, active low
        logic       iow_n;    // i/o write strobe, active low
        logic [7:0] data;     // data lines driven by the host
    } fdos_isa_in_t;

    // data lines driven back toward the host
    typedef struct packed {
        logic [7:0] data;     // read data
        logic       oe;       // high while this block drives the lines
    } fdos_isa_out_t;

    // outputs toward the drive interface, active high
    typedef struct packed {
        logic [3:0] motor_on;             // motor enables, drive 3 down to 0
        logic [3:0] drive_select_outputs; // one-hot drive selects
    } fdos_drive_out_t;

endpackage : fdos_pkg

// [src/fdos_sync.sv]
// two flip-flop synchroniser for a bundle of asynchronous levels.
// assumes each bit is a level held for several clock periods.
`timescale 1ns/1ps
module fdos_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE  = '0
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // levels in and out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    import fdos_pkg::*;

    // width must be at least one bit
    if (WIDTH < 1) begin : g_chk
        $error("fdos_sync width below one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;   // first stage, read only by the second
        logic [WIDTH-1:0] stable; // second stage, safe to use
    } fdos_sync_state_t;

    fdos_sync_state_t state_q;
    fdos_sync_state_t state_d;

    // next state: shift one stage
    always_comb begin
        state_d        = state_q;
        state_d.meta   = async_i;
        state_d.stable = state_q.meta;
    end

    // registers start at the idle levels, so a cleared stage never looks
    // like an active-low strobe or pulse edge right after reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q.meta   <= IDLE;
            state_q.stable <= IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_o = state_q.stable;

endmodule : fdos_sync

// [src/fdos_dsel_dec.sv]
// binary to one-hot drive select decoder with a registered output.
// assumes the select code comes from a register on the same clock.
`timescale 1ns/1ps
module fdos_dsel_dec #(
    parameter int SEL_W  = 2,
    parameter int DRIVES = 4
) (
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    // select code and decoded lines
    input  wire logic [SEL_W-1:0]  dsel_i,
    output logic      [DRIVES-1:0] drive_select_o
);
    import fdos_pkg::*;

    // the code must cover exactly the drive count
    if (DRIVES != (1 << SEL_W)) begin : g_chk
        $error("fdos_dsel_dec drive count does not match select width");
    end

    typedef struct packed {
        logic [DRIVES-1:0] onehot; // registered decode
    } fdos_dec_state_t;

    fdos_dec_state_t state_q;
    fdos_dec_state_t state_d;

    // one-hot decode; a binary code can never raise two lines
    function automatic logic [DRIVES-1:0] fdos_decode(input logic [SEL_W-1:0] code);
        logic [DRIVES-1:0] res;
        res = '0;
        for (int i = 0; i < DRIVES; i++) begin
            res[i] = (code == SEL_W'(i));
        end
        return res;
    endfunction : fdos_decode

    // next state
    always_comb begin
        state_d        = state_q;
        state_d.onehot = fdos_decode(dsel_i);
    end

    // after hardware reset drive zero is selected, matching a cleared code
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= fdos_dec_state_t'({{(DRIVES-1){1'b0}}, 1'b1});
        end else begin
            state_q <= state_d;
        end
    end

    assign drive_select_o = state_q.onehot;

endmodule : fdos_dsel_dec

// [src/fdos_regs.sv]
// drive output control and drive signal status registers, reached over
// isa i/o cycles, with the software reset of the diskette controller.
// assumes an external base decoder gives cs_n (aliased or not), and that
// the write pulse and write gate come from the controller core on clock_i.
//
// Operation
// - read-only drive signal status at offset one
// - status bit five mirrors drive select bit
// - mirrored select cleared by hardware reset only
// - bit four toggles per write pulse end
// - bit three toggles per read pulse end
// - bit two reports write gate high
// - bit one reports drive one motor
// - bit zero reports drive zero motor
// - read/write drive output control at offset two
// - bits seven to four drive motor enables
// - bit two zero holds controller in reset
// - software reset keeps other register bits
// - bits one-zero decode to one drive select
`timescale 1ns/1ps
`include "fdos_cfg.svh"
module fdos_regs (
    // clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    // isa i/o side
    input  wire fdos_pkg::fdos_isa_in_t isa_i,
    output fdos_pkg::fdos_isa_out_t     isa_o,
    // controller core side
    input  wire logic                   write_gate_line_i,
    input  wire logic                   wr_pulse_n_i,
    output logic                        ctrl_reset_o,
    // drive side
    input  wire logic                   rd_pulse_n_i,
    output fdos_pkg::fdos_drive_out_t   drive_o
);
    import fdos_pkg::*;

    localparam int SWRST_MIN = `FDOS_SWRST_MIN_CYC; // cycles in software reset
    localparam int HOLD_W    = (SWRST_MIN < 2) ? 1 : $clog2(SWRST_MIN + 1);

    // the minimum must be at least one cycle
    if (SWRST_MIN < 1) begin : g_chk
        $error("fdos_regs software reset minimum below one cycle");
    end

    // all state of the block
    typedef struct packed {
        logic [7:0]        outctl;    // drive output control byte
        logic              wr_tog;    // write pulse toggle
        logic              rd_tog;    // read pulse toggle
        logic              wr_prev;   // last write pulse level
        logic              rd_prev;   // last synchronised read pulse level
        logic              iow_prev;  // last synchronised write strobe
        logic              wsel;      // write cycle addressed to this block
        logic [2:0]        waddr;     // captured write offset
        logic [7:0]        wdata;     // captured write byte
        logic              rd_oe;     // drive read data toward host
        logic [7:0]        rdata;     // read data toward host
        logic [HOLD_W-1:0] hold_cnt;  // cycles spent in software reset
        logic              ctrl_rst;  // controller held in reset
    } fdos_regs_state_t;

    fdos_regs_state_t state_q;
    fdos_regs_state_t state_d;

    // synchronised copies of the pins
    logic              s_aen;       // address enable
    logic              s_cs_n;      // base decode
    logic [2:0]        s_addr;      // offset
    logic              s_ior_n;     // read strobe
    logic              s_iow_n;     // write strobe
    logic [7:0]        s_data;      // write data
    logic              s_rd_pulse;  // read pulse from drive
    // decoded helpers
    logic              selected;    // this block addressed
    logic              commit;      // write ends this cycle
    logic              wr_edge;     // write pulse went inactive
    logic              rd_edge;     // read pulse went inactive
    logic [7:0]        status_byte; // live drive signal status
    logic [3:0]        dsel_lines;  // decoded selects

    // every isa pin and the drive read pulse cross into clock_i here; the
    // stages start at idle levels so no false strobe or edge follows reset
    fdos_sync #(
        .WIDTH (16),
        .IDLE  (`FDOS_SYNC_IDLE)
    ) fdos_sync_inst (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i ({isa_i.aen, isa_i.cs_n, isa_i.addr, isa_i.ior_n,
                   isa_i.iow_n, isa_i.data, rd_pulse_n_i}),
        .sync_o  ({s_aen, s_cs_n, s_addr, s_ior_n, s_iow_n, s_data, s_rd_pulse})
    );

    // drive select decode, registered inside
    fdos_dsel_dec #(
        .SEL_W  (2),
        .DRIVES (4)
    ) fdos_dsel_dec_inst (
        .clock_i        (clock_i),
        .rst_n_i        (rst_n_i),
        .dsel_i         (state_q.outctl[`FDOS_OC_DSEL_HI:`FDOS_OC_DSEL_LO]),
        .drive_select_o (dsel_lines)
    );

    // decode and edge detection
    always_comb begin
        // only i/o cycles count; dma cycles raise aen and are ignored
        selected = !s_aen && !s_cs_n;
        // a write takes effect when its strobe returns high
        commit   = state_q.wsel && !state_q.iow_prev && s_iow_n;
        // inactive edge of an active-low pulse is its rising edge
        wr_edge  = !state_q.wr_prev && wr_pulse_n_i;
        rd_edge  = !state_q.rd_prev && s_rd_pulse;
        // status byte assembled from live state; reserved bits read zero
        status_byte = `FDOS_BYTE_ZERO;
        status_byte[`FDOS_ST_DSEL0]     = state_q.outctl[`FDOS_OC_DSEL_LO];
        status_byte[`FDOS_ST_WR_TOGGLE] = state_q.wr_tog;
        status_byte[`FDOS_ST_RD_TOGGLE] = state_q.rd_tog;
        status_byte[`FDOS_ST_WRITE_GATE_LINE]     = write_gate_line_i;
        status_byte[`FDOS_ST_MOTOR1]    = state_q.outctl[`FDOS_OC_MOTOR_LO + 1];
        status_byte[`FDOS_ST_MOTOR0]    = state_q.outctl[`FDOS_OC_MOTOR_LO];
    end

    // next state of the whole block
    always_comb begin
        state_d          = state_q;
        state_d.wr_prev  = wr_pulse_n_i;
        state_d.rd_prev  = s_rd_pulse;
        state_d.iow_prev = s_iow_n;

        // write cycle: keep capturing while the strobe is low, so the
        // byte taken is the last one seen before the strobe rose
        if (!s_iow_n) begin
            state_d.wsel  = selected;
            state_d.waddr = s_addr;
            state_d.wdata = s_data;
        end else if (commit) begin
            state_d.wsel  = 1'b0;
        end

        // only the output control byte is writable; the status is read-only
        if (commit && state_q.waddr == `FDOS_OFS_OUTCTL) begin
            state_d.outctl = state_q.wdata;
            state_d.outctl[`FDOS_OC_RSVD] = 1'b0;
        end

        // read cycle: the answer is refreshed every cycle of the strobe
        state_d.rd_oe = 1'b0;
        state_d.rdata = `FDOS_BYTE_ZERO;
        if (!s_ior_n && selected) begin
            if (s_addr == `FDOS_OFS_STATUS) begin
                state_d.rd_oe = 1'b1;
                state_d.rdata = status_byte;
            end else if (s_addr == `FDOS_OFS_OUTCTL) begin
                state_d.rd_oe = 1'b1;
                state_d.rdata = state_q.outctl;
            end
        end

        // software reset: count time spent with the reset bit low
        if (!state_q.outctl[`FDOS_OC_NRESET]) begin
            state_d.ctrl_rst = 1'b1;
            if (state_q.hold_cnt < HOLD_W'(SWRST_MIN)) begin
                state_d.hold_cnt = state_q.hold_cnt + HOLD_W'(1);
            end
        end else if (!state_q.ctrl_rst) begin
            // running: the counter rests so the next reset counts from zero
            state_d.hold_cnt = '0;
        end else if (state_q.hold_cnt >= HOLD_W'(SWRST_MIN)) begin
            // a release written too early waits out the minimum
            state_d.ctrl_rst = 1'b0;
            state_d.hold_cnt = '0;
        end else begin
            state_d.hold_cnt = state_q.hold_cnt + HOLD_W'(1);
        end

        // toggles clear in software reset; the control byte is untouched
        // by it, which keeps the mirrored select bit as well
        if (state_q.ctrl_rst) begin
            state_d.wr_tog = 1'b0;
            state_d.rd_tog = 1'b0;
        end else begin
            if (wr_edge) begin
                state_d.wr_tog = !state_q.wr_tog;
            end
            if (rd_edge) begin
                state_d.rd_tog = !state_q.rd_tog;
            end
        end
    end

    // hardware reset clears the control byte and holds the controller
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q          <= '0;
            state_q.outctl   <= `FDOS_OC_RESET_VAL;
            state_q.wr_prev  <= 1'b1;
            state_q.rd_prev  <= 1'b1;
            state_q.iow_prev <= 1'b1;
            state_q.ctrl_rst <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs, all from flip-flops
    assign isa_o.data                   = state_q.rdata;
    assign isa_o.oe                     = state_q.rd_oe;
    assign ctrl_reset_o                 = state_q.ctrl_rst;
    assign drive_o.motor_on             = state_q.outctl[`FDOS_OC_MOTOR_HI:`FDOS_OC_MOTOR_LO];
    assign drive_o.drive_select_outputs = dsel_lines;

    // status read carries the live selected drive bit
    a_dsel_mirror: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!s_ior_n && selected && s_addr == `FDOS_OFS_STATUS)
        |=> (isa_o.oe && isa_o.data[`FDOS_ST_DSEL0] == $past(state_q.outctl[0])))
        else $error("status select bit does not mirror control byte");

    // software reset alone never changes the control byte
    a_swrst_keeps_ctl: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_q.ctrl_rst && !commit) |=> $stable(state_q.outctl))
        else $error("control byte changed without a write");

    // write pulse end flips the toggle outside reset
    a_wr_toggle_flip: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (wr_edge && !state_q.ctrl_rst) |=> (state_q.wr_tog != $past(state_q.wr_tog)))
        else $error("write toggle missed an edge");

    // read pulse end flips the toggle outside reset
    a_rd_toggle_flip: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (rd_edge && !state_q.ctrl_rst) |=> (state_q.rd_tog != $past(state_q.rd_tog)))
        else $error("read toggle missed an edge");

    // toggles read zero once reset is in force
    a_toggle_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_q.ctrl_rst |=> (!state_q.wr_tog && !state_q.rd_tog))
        else $error("toggle bits not cleared in software reset");

    // gate and motor bits reach the status byte
    a_status_lines: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!s_ior_n && selected && s_addr == `FDOS_OFS_STATUS)
        |=> (isa_o.data[2] == $past(write_gate_line_i)
             && isa_o.data[1:0] == $past(state_q.outctl[5:4])))
        else $error("status byte misreports gate or motor lines");

    // a committed write sets the motor outputs one cycle later
    a_motor_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (commit && state_q.waddr == `FDOS_OFS_OUTCTL)
        |=> (drive_o.motor_on == $past(state_q.wdata[7:4])))
        else $error("motor outputs do not follow written byte");

    // reset bit low keeps the controller in reset
    a_swrst_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !state_q.outctl[`FDOS_OC_NRESET] |=> ctrl_reset_o)
        else $error("controller left reset while reset bit low");

    // a release never comes earlier than the minimum
    a_swrst_min: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(ctrl_reset_o) |-> ctrl_reset_o [*2])
        else $error("software reset shorter than minimum");

    // selects follow the code one cycle after it changes, one at a time
    a_dsel_decode: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ##1 (drive_o.drive_select_outputs == (4'h1 << $past(state_q.outctl[1:0]))))
        else $error("drive selects do not decode the control code");

    // dma and deselected write cycles are never taken
    a_refused_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!s_iow_n && !selected) |=> !state_q.wsel)
        else $error("write cycle taken while not addressed");

    // dma and deselected read cycles never drive the data lines
    a_refused_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!s_ior_n && !selected) |=> !isa_o.oe)
        else $error("read data driven while not addressed");

    // the unused control bit is never stored
    a_ctl_rsvd_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !state_q.outctl[`FDOS_OC_RSVD])
        else $error("reserved control bit stored");

    // status bits seven and six read zero whatever the motors do
    a_status_rsvd: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!s_ior_n && selected && s_addr == `FDOS_OFS_STATUS)
        |=> (isa_o.data[7:6] == 2'h0))
        else $error("reserved status bits not zero");

    // never more than one drive selected
    a_select_onehot: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $onehot(drive_o.drive_select_outputs))
        else $error("drive selects not one-hot");

    // main scenarios
    c_status_read: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        isa_o.oe && !state_q.ctrl_rst && state_q.rd_tog);
    c_ctl_write: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        commit && state_q.waddr == `FDOS_OFS_OUTCTL && state_q.wdata[7:4] != 4'h0);
    c_swrst_release: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        $fell(ctrl_reset_o));
    c_refused_cycle: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        !s_iow_n && s_aen);

endmodule : fdos_regs

// [tb/fdos_drive_model.sv]
// behavioural diskette drive on the far side of the register block.
// assumes the bench calls read_pulses and that the read line idles high.
`timescale 1ns/1ps
module fdos_drive_model (
    // clock used only to pace the pulses
    input  wire logic                      clock_i,
    // outputs of the block toward the drives
    input  wire fdos_pkg::fdos_drive_out_t drive_i,
    // read data line back to the block, active low
    output logic                           rd_pulse_n_o
);
    import fdos_pkg::*;

    // the line is pulled up, so it sits inactive between pulses
    initial rd_pulse_n_o = 1'b1;

    // a stopped spindle yields no flux, so no pulses leave the drive
    task automatic read_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clock_i);
            if (drive_i.motor_on != 4'h0) begin
                rd_pulse_n_o = 1'b0;
            end
            repeat (4) @(negedge clock_i);
            rd_pulse_n_o = 1'b1;
            repeat (4) @(negedge clock_i);
        end
    endtask : read_pulses
endmodule : fdos_drive_model

// [tb/test_floppy_drive_output_status_regs.sv]
// self-checking bench for the drive output and drive signal status pair.
// assumes fdos_regs, its package and header, and the drive model.
`timescale 1ns/1ps
`define CHK(got, exp, what) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %0t %s got %h exp %h", $time, what, got, exp); end end
module test_floppy_drive_output_status_regs;
    import fdos_pkg::*;
    logic            clock_i = 1'b0; // 10 MHz clock
    logic            rst_n_i = 1'b0; // hardware reset, active low
    fdos_isa_in_t    isa;            // host i/o cycle
    fdos_isa_out_t   isa_o;          // read data back
    logic            write_gate_line   = 1'b0; // write gate from the core
    logic            wr_n    = 1'b1; // write pulse, idle high
    logic            rd_n;           // read pulse from the drive
    logic            ctrl_rst;       // software reset state
    fdos_drive_out_t drv;            // drive side outputs
    logic [7:0]      rdat;           // last byte read
    int              n_fail   = 0;
    int              n_checks = 0;

    // clock: half period of 50 ns
    always #50 clock_i = ~clock_i;

    // idle bus at time zero, strobes high so the synchronisers start clean
    initial isa = '{aen: 1'b0, cs_n: 1'b1, addr: 3'h0, ior_n: 1'b1, iow_n: 1'b1,
                    data: 8'h00};

    fdos_regs fdos_regs_inst (
        .clock_i           (clock_i),
        .rst_n_i           (rst_n_i),
        .isa_i             (isa),
        .isa_o             (isa_o),
        .write_gate_line_i (write_gate_line),
        .wr_pulse_n_i      (wr_n),
        .ctrl_reset_o      (ctrl_rst),
        .rd_pulse_n_i      (rd_n),
        .drive_o           (drv)
    );

    fdos_drive_model fdos_drive_model_inst (
        .clock_i      (clock_i),
        .drive_i      (drv),
        .rd_pulse_n_o (rd_n)
    );

    task automatic step(input int n);
        repeat (n) @(negedge clock_i);
    endtask : step

    // one i/o cycle; strobe held 4 cycles, then 6 high so the commit lands
    task automatic io(input logic wr, input logic [2:0] a, input logic [7:0] d,
                      input logic aen = 1'b0, input logic cs_n = 1'b0);
        logic exp_oe;
        exp_oe = !(aen | cs_n) && (a == 3'h1 || a == 3'h2);
        @(negedge clock_i);
        isa.aen = aen;
        isa.cs_n = cs_n;
        isa.addr = a;
        isa.data = d;
        if (wr) begin
            isa.iow_n = 1'b0;
        end else begin
            isa.ior_n = 1'b0;
        end
        step(4);
        rdat = isa_o.data;
        if (!wr) `CHK(isa_o.oe, exp_oe, "read drive enable")
        isa.iow_n = 1'b1;
        isa.ior_n = 1'b1;
        step(6);
        `CHK(isa_o.oe, 1'b0, "drive enable released")
        isa.cs_n = 1'b1;
    endtask : io

    // compare pins and both registers against one control byte
    task automatic expect_ctl(input logic [7:0] v);
        logic [3:0] sel;
        sel = 4'h1 << v[1:0];
        `CHK(drv.motor_on, v[7:4], "motor enables")
        `CHK(drv.drive_select_outputs, sel, "drive selects")
        `CHK(ctrl_rst, ~v[2], "controller reset")
        io(1'b0, 3'h2, 8'h00);
        `CHK(rdat, v & 8'hF7, "control readback")
        io(1'b0, 3'h1, 8'h00);
        `CHK(rdat[5], v[0], "select mirror")
        `CHK(rdat[1:0], v[5:4], "motor mirror")
    endtask : expect_ctl

    // after power-up motors are off, drive zero is selected, the controller is in reset and the status byte is clear
    task automatic t_reset_values;
        expect_ctl(8'h00);
        `CHK(rdat, 8'h00, "status after reset")
    endtask : t_reset_values

    // every select code, each with its own motor; bit 3 written but not kept
    task automatic t_codes;
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            v = {4'(1 << i), 2'b11, 2'(i)};
            io(1'b1, 3'h2, v);
            expect_ctl(v);
        end
    endtask : t_codes

    // dma cycles, deselected cycles and other offsets must not write
    task automatic t_refused;
        io(1'b1, 3'h2, 8'h00, 1'b1, 1'b0);
        io(1'b1, 3'h2, 8'h00, 1'b0, 1'b1);
        io(1'b1, 3'h1, 8'h00);
        io(1'b1, 3'h3, 8'h00);
        io(1'b0, 3'h2, 8'h00, 1'b1, 1'b0);
        io(1'b0, 3'h0, 8'h00);
        expect_ctl(8'h8F);
    endtask : t_refused

    // write gate level and both pulse toggles, odd counts leave ones
    task automatic t_drive_signals;
        write_gate_line = 1'b1;
        for (int i = 0; i < 3; i++) begin
            step(1);
            wr_n = 1'b0;
            step(2);
            wr_n = 1'b1;
        end
        fdos_drive_model_inst.read_pulses(5);
        io(1'b0, 3'h1, 8'h00);
        `CHK(rdat[4:2], 3'b111, "write toggle, read toggle, gate")
        write_gate_line = 1'b0;
    endtask : t_drive_signals

    // software reset keeps the other bits and the mirror, clears toggles
    task automatic t_soft_reset;
        io(1'b1, 3'h2, 8'h8B);
        expect_ctl(8'h8B);
        `CHK(rdat[5:2], 4'b1000, "status in soft reset")
        // the bit stays low for many cycles, well past the minimum
        io(1'b1, 3'h2, 8'h8F);
        expect_ctl(8'h8F);
    endtask : t_soft_reset

    // hardware reset in mid-run clears the register and the mirror
    task automatic t_hw_reset;
        rst_n_i = 1'b0;
        step(2);
        rst_n_i = 1'b1;
        step(4);
        expect_ctl(8'h00);
    endtask : t_hw_reset

    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // main sequence
    initial begin
        step(16);
        rst_n_i = 1'b1;
        step(4);
        t_reset_values;
        t_codes;
        t_refused;
        t_drive_signals;
        t_soft_reset;
        t_hw_reset;
        finish_test;
    end

    // watchdog: the run needs under 1500 cycles, give it 5000
    initial begin
        #(5000 * 100);
        n_fail++;
        finish_test;
    end
endmodule : test_floppy_drive_output_status_regs
